// ### bench/hbtr_regs_monitor.sv
// Concurrent checks on the ports of the host bridge tuning register bank.
// Assumes one host clock domain and the asynchronous active-low reset of the block.
`timescale 1ns/10ps

module hbtr_regs_monitor
   import hbtr_pkg::*;
#(
   parameter int REF_CYCLES = 20
) (
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic hreadyout_o,
   input wire logic hresp_o,
   input wire logic [31:0] hrdata_o,
   input wire hbtr_pkg::hbtr_io_wr_t io_wr_i,
   input wire logic post_buf_full_i,
   input wire logic parity_err_i,
   input wire logic processor_reset_out_o,
   input wire logic burst_ready_n_o,
   input wire logic refresh_req_o,
   input wire logic parity_err_o,
   input wire hbtr_pkg::hbtr_settings_t settings_o
);
   // ---------------------------------------------
   // Helper counters for the reset sequence
   // ---------------------------------------------
   logic arm_reg;
   logic [9:0] wait_reg;
   logic [5:0] hold_reg;
   logic cmd;
   assign cmd = io_wr_i.valid && io_wr_i.addr == 16'h0064 && io_wr_i.data[7:4] == 4'hf
      && !io_wr_i.data[0];
   // Arm expires after the long delay so an ignored command cannot linger
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         arm_reg <= 1'b0;
         wait_reg <= 10'h000;
         hold_reg <= 6'h00;
      end else begin
         hold_reg <= processor_reset_out_o ? hold_reg + 6'h01 : 6'h00;
         if (!arm_reg) begin
            arm_reg <= cmd && !processor_reset_out_o;
            wait_reg <= 10'h000;
         end else begin
            wait_reg <= wait_reg + 10'h001;
            if (processor_reset_out_o || wait_reg > 10'h320) begin
               arm_reg <= 1'b0;
            end
         end
      end
   end
   // ---------------------------------------------
   // Properties
   // ---------------------------------------------
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!nrst_i);
   property p_bus_okay; hreadyout_o == 1'b1 && hresp_o == 1'b0; endproperty
   a_bus_okay: assert property (p_bus_okay) else $error("bus not ready or not okay");
   property p_rdata_hi; hrdata_o[31:8] == 24'h000000; endproperty
   a_rdata_hi: assert property (p_rdata_hi) else $error("read data upper bits set");
   property p_fr_delay;
      $rose(processor_reset_out_o) |-> arm_reg && (wait_reg inside {[10'h0f8:10'h0fd],
         [10'h2ec:10'h2f1]});
   endproperty
   a_fr_delay: assert property (p_fr_delay) else $error("reset delay wrong");
   property p_fr_len; $fell(processor_reset_out_o) |-> hold_reg == 6'h19; endproperty
   a_fr_len: assert property (p_fr_len) else $error("reset hold length wrong");
   property p_fr_max; processor_reset_out_o |-> hold_reg < 6'h19; endproperty
   a_fr_max: assert property (p_fr_max) else $error("reset held too long");
   property p_burst_ready_n_pulse; !burst_ready_n_o |=> burst_ready_n_o; endproperty
   a_burst_ready_n_pulse: assert property (p_burst_ready_n_pulse) else $error("ready pulse too long");
   property p_burst_ready_n_full; !burst_ready_n_o |-> !$past(post_buf_full_i); endproperty
   a_burst_ready_n_full: assert property (p_burst_ready_n_full) else $error("ready while buffer full");
   property p_ref_pulse; refresh_req_o |=> !refresh_req_o; endproperty
   a_ref_pulse: assert property (p_ref_pulse) else $error("refresh pulse too long");
   property p_parity; parity_err_o |-> $past(parity_err_i); endproperty
   a_parity: assert property (p_parity) else $error("parity error without cause");
   property p_pci_sel; settings_o.pci_clk_sel != 2'h2; endproperty
   a_pci_sel: assert property (p_pci_sel) else $error("reserved clock code driven");
   property p_range; settings_o.burst_range inside {11'h200, 11'h400}; endproperty
   a_range: assert property (p_range) else $error("burst range illegal");
   property p_drive; settings_o.cas_drive_ma inside {4'h4, 4'h8, 4'hc}; endproperty
   a_drive: assert property (p_drive) else $error("drive current illegal");
   c_fr: cover property ($fell(processor_reset_out_o));
   c_burst_ready_n: cover property ($fell(burst_ready_n_o));
   c_ref: cover property (refresh_req_o);
endmodule

bind hbtr_regs hbtr_regs_monitor #(.REF_CYCLES(REF_CYCLES)) i_hbtr_regs_monitor (
   .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
   .hrdata_o(hrdata_o), .io_wr_i(io_wr_i), .post_buf_full_i(post_buf_full_i),
   .parity_err_i(parity_err_i), .processor_reset_out_o(processor_reset_out_o),
   .burst_ready_n_o(burst_ready_n_o), .refresh_req_o(refresh_req_o),
   .parity_err_o(parity_err_o), .settings_o(settings_o));

// ### bench/hbtr_regs_tb.sv
// Self-checking bench for the host bridge tuning register bank.
// Assumes the monitor is bound to hbtr_regs; the bench is the only bus master.
`timescale 1ns/10ps

module hbtr_regs_tb;
   import hbtr_pkg::*;
   localparam int REF = 20;
   localparam logic [31:0] A_RRT = 32'h0000016c;
   localparam logic [31:0] A_BLC = 32'h00000170;
   localparam logic [31:0] A_PCI = 32'h00000174;
   localparam logic [31:0] ADDRS [4] = '{A_RRT, A_BLC, A_PCI, 32'h00000178};
   localparam logic [31:0] ONES_RD [4] = '{32'h7f, 32'hff, 32'hff, 32'h0};
   localparam logic [31:0] DRV_MA [4] = '{32'h8, 32'h4, 32'hc, 32'h8};
   localparam logic [31:0] THR_CFG [3] = '{32'h0, 32'h2, 32'h6};
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   hbtr_io_wr_t io_wr = '0;
   logic ads_n = 1'b1;
   logic hit = 1'b0, cpu_wr = 1'b0, full = 1'b0, held = 1'b0;
   logic dturbo = 1'b0, perr_in = 1'b0, drv1 = 1'b0;
   logic hreadyout, hresp, rst_out, burst_ready_n_n, refr, thr, perr_out;
   logic [31:0] hrdata;
   logic [31:0] v;
   hbtr_settings_t sets;
   int fails = 0;
   int checked = 0;
   int cyc = 0;
   int n;
   int i;

   hbtr_regs #(.REF_CYCLES(REF)) i_hbtr_regs (
      .sys_clk_i(clk), .nrst_i(nrst), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
      .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hreadyout),
      .hreadyout_o(hreadyout), .hresp_o(hresp), .hrdata_o(hrdata), .io_wr_i(io_wr),
      .address_strobe_n_i(ads_n), .local_hit_i(hit), .cpu_write_i(cpu_wr),
      .post_buf_full_i(full), .cpu_held_i(held), .deturbo_switch_i(dturbo),
      .parity_err_i(perr_in), .cas_drive_bit1_i(drv1), .processor_reset_out_o(rst_out),
      .burst_ready_n_o(burst_ready_n_n), .refresh_req_o(refr), .throttle_hold_o(thr),
      .parity_err_o(perr_out), .settings_o(sets));

   always #4 clk = ~clk;
   // ---------------------------------------------
   // Bench tasks
   // ---------------------------------------------
   task complete_run;
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // Guards against a hung handshake or wait loop
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         fails++;
         complete_run();
      end
   end
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task xfer(input logic w, input logic [31:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk); while (hreadyout !== 1'b1);
      v = hrdata;
   endtask
   // Two idle edges let the registered settings follow the write
   task wr(input logic [31:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
      repeat (2) @(posedge clk);
   endtask
   task rdchk(input logic [31:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      chk(v, exp);
   endtask
   task send(input logic [7:0] d);
      io_wr <= '{1'b1, 16'h0064, d};
      @(posedge clk);
      io_wr.valid <= 1'b0;
   endtask
   task post(input logic h, input logic w);
      ads_n <= 1'b0;
      hit <= h;
      cpu_wr <= w;
      @(posedge clk);
      ads_n <= 1'b1;
   endtask
   function automatic logic seen_evt(input int sel);
      case (sel)
         0: return rst_out === 1'b1;
         1: return burst_ready_n_n === 1'b0;
         2: return refr === 1'b1;
         default: return rst_out === 1'b0;
      endcase
   endfunction
   task wait_for(input int sel, input int lim, output int cnt);
      cnt = 0;
      do begin
         @(posedge clk);
         cnt++;
      end while (cnt < lim && !seen_evt(sel));
   endtask
   // ---------------------------------------------
   // Main sequence
   // ---------------------------------------------
   initial begin
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      for (i = 0; i < 4; i++) begin
         rdchk(ADDRS[i], 32'h0);
         wr(ADDRS[i], 32'hffffffff);
         rdchk(ADDRS[i], ONES_RD[i]);
      end
      chk(32'(sets.cas_push_dly), 32'h1);
      chk(32'(sets.cas_pulse_w), 32'h2);
      chk(32'({sets.kwe_host_sync, sets.tag7, sets.snoop_en}), 32'h7);
      chk(32'(sets.burst_range), 32'h400);
      for (i = 0; i < 4; i++) begin
         wr(ADDRS[i], 32'h0);
      end
      chk(32'({sets.cas_push_dly, sets.cas_pulse_w, sets.kwe_host_sync}), 32'h12);
      chk(32'(sets.burst_range), 32'h200);
      for (i = 0; i < 4; i++) begin
         wr(A_PCI, 32'(i) << 6);
         chk(32'(sets.pci_clk_sel), i == 2 ? 32'h0 : 32'(i));
         drv1 <= i[1];
         wr(A_RRT, 32'(i[0]));
         chk(32'(sets.cas_drive_ma), DRV_MA[i]);
      end
      for (i = 0; i < 2; i++) begin
         wr(A_BLC, 32'(i));
         perr_in <= 1'b1;
         @(posedge clk);
         perr_in <= 1'b0;
         @(posedge clk);
         chk(32'(perr_out), 32'(1 - i));
      end
      $display("done: registers and settings");
      for (i = 0; i < 2; i++) begin
         wr(A_BLC, i ? 32'h80 : 32'h0);
         post(1'b0, 1'b1);
         wait_for(1, 10, n);
         // Ready sampled 4 or 3 edges after the strobe edge gives the 5T or 4T rate
         chk(n, 4 - i);
      end
      post(1'b1, 1'b1);
      wait_for(1, 10, n);
      chk(n, 10);
      post(1'b0, 1'b0);
      wait_for(1, 10, n);
      chk(n, 10);
      for (i = 0; i < 2; i++) begin
         wr(A_BLC, i ? 32'h08 : 32'h0);
         full <= 1'b1;
         post(1'b0, 1'b1);
         wait_for(1, 8, n);
         chk(n, 8);
         full <= 1'b0;
         wait_for(1, 8, n);
         chk(n, 2 + i);
      end
      $display("done: posted writes");
      for (i = 0; i < 2; i++) begin
         wr(A_RRT, i ? 32'h60 : 32'h40);
         send(i ? 8'hfe : 8'hf0);
         wait_for(0, 900, n);
         chk(32'(n >= 250 + 500 * i && n <= 252 + 500 * i), 32'h1);
         wait_for(3, 40, n);
         chk(n, 25);
      end
      send(8'hf1);
      wait_for(0, 900, n);
      chk(n, 900);
      wr(A_RRT, 32'h0);
      send(8'hf0);
      wait_for(0, 900, n);
      chk(n, 900);
      $display("done: fast reset");
      for (i = 0; i < 2; i++) begin
         wr(A_RRT, i ? 32'h10 : 32'h0);
         wait_for(2, 200, n);
         wait_for(2, 200, n);
         chk(n, REF * (1 + 3 * i));
      end
      wr(A_RRT, 32'h0);
      held <= 1'b1;
      wait_for(2, 100, n);
      chk(n, 100);
      wr(A_BLC, 32'h40);
      wait_for(2, 200, n);
      wait_for(2, 200, n);
      chk(n, REF);
      held <= 1'b0;
      $display("done: refresh");
      dturbo <= 1'b1;
      for (i = 0; i < 3; i++) begin
         wr(A_RRT, THR_CFG[i]);
         repeat (1600) @(posedge clk);
         n = 0;
         repeat (1500) begin
            @(posedge clk);
            n += (thr === 1'b1) ? 1 : 0;
         end
         chk(n, 500 * i);
      end
      $display("done: throttle");
      complete_run();
   end
endmodule

// ### common/hbtr_cfg.svh
// Constants of the host bridge tuning register bank: offsets, fields, reset values, timing.
// Assumes a 125 MHz host clock and word-indexed register placement on AHB-Lite.
//
// Summary of operation
// R01: Enabled fast reset decodes I/O write to port 64h with data 1111xxx0b.
// R02: Processor reset waits 2 us (latency bit 0) or 6 us (bit 1) after command.
// R03: Processor reset then stays asserted for exactly 25 host clocks.
// R04: Slow refresh bit set gives refresh at one quarter of normal rate.
// R05: Write push to column strobe delay is two clocks (bit 0) or one (bit 1).
// R06: De-turbo holds processor 4 us, or 8 us of every 12 us when bit set.
// R07: De-turbo switch disabled means always turbo; enabled honours the switch input.
// R08: Local memory decode result sampled three clocks after address strobe, or two.
// R09: Posted write returns burst ready one clock after miss decision if buffer not full.
// R10: Posted double-word writes complete every 5 clocks, or 4 with fast decode.
// R11: Posted quad-word write takes 8 clocks, or 7 with fast decode.
// R12: Refresh continues while processor is held only when enable bit is set.
// R13: Column strobe pulse in PCI master writes lasts one clock, or two.
// R14: After buffer leaves full, burst ready comes after one clock, or two.
// R15: Cache write enable synchronised to auxiliary clock (bit 0) or host clock (bit 1).
// R16: Memory parity error detection active when bit is 0, suppressed when 1.
// R17: PCI clock field: 00 host/2, 01 host/1.5, 11 14 MHz, 10 reserved.
// R18: PCI master burst address range limited to 512 bytes, or 1 KB.
// R19: Drive bit pairs with second bit: 00 8mA, 10 4mA, 01 12mA, 11 8mA.
// R20: Every configuration bit reads back the value last written.
`ifndef HBTR_CFG_SVH
`define HBTR_CFG_SVH

// ---------------------------------------------------------------
// Register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define HBTR_IDX_RRT 8'h5b
`define HBTR_IDX_BLC 8'h5c
`define HBTR_IDX_PCI 8'h5d
`define HBTR_RST_RRT 8'h00
`define HBTR_RST_BLC 8'h00
`define HBTR_RST_PCI 8'h00
`define HBTR_RRT_MASK 8'h7f

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define HBTR_RRT_FR_EN 6
`define HBTR_RRT_FR_LAT 5
`define HBTR_RRT_SLOW_REF 4
`define HBTR_RRT_PUSH_DLY 3
`define HBTR_RRT_DT_HOLD 2
`define HBTR_RRT_DT_EN 1
`define HBTR_RRT_DRV0 0
`define HBTR_BLC_DEC_LAT 7
`define HBTR_BLC_REF_HOLD 6
`define HBTR_BLC_SNOOP 5
`define HBTR_BLC_CAS_W 4
`define HBTR_BLC_FULL_LAT 3
`define HBTR_BLC_KWE_SEL 2
`define HBTR_BLC_TAG7 1
`define HBTR_BLC_PAR_DIS 0
`define HBTR_PCI_CLK_HI 7
`define HBTR_PCI_CLK_LO 6
`define HBTR_PCI_BURST 5

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define HBTR_CLK_PERIOD_NS 8
`define HBTR_FR_SHORT_NS 2000
`define HBTR_FR_LONG_NS 6000
`define HBTR_FR_HOLD_CYC 25
`define HBTR_DT_SHORT_NS 4000
`define HBTR_DT_LONG_NS 8000
`define HBTR_DT_PERIOD_NS 12000
`define HBTR_NS2CYC(ns) (((ns) + `HBTR_CLK_PERIOD_NS - 1) / `HBTR_CLK_PERIOD_NS)
`define HBTR_REF_CYC 1950
`define HBTR_SLOW_FACTOR 4
`define HBTR_FR_PORT 16'h0064
`define HBTR_FR_DATA_HI 4'hf

`endif

// ### common/hbtr_pkg.sv
// Types of the host bridge tuning register bank.
// Assumes hbtr_cfg.svh for all numeric constants.
package hbtr_pkg;

   // I/O write snooped from the host bus
   typedef struct packed {
      logic valid;
      logic [15:0] addr;
      logic [7:0] data;
   } hbtr_io_wr_t;

   // Settings presented to the memory, cache and PCI engines
   typedef struct packed {
      logic [1:0] cas_push_dly;
      logic [1:0] cas_pulse_w;
      logic kwe_host_sync;
      logic tag7;
      logic snoop_en;
      logic [1:0] pci_clk_sel;
      logic [10:0] burst_range;
      logic [3:0] cas_drive_ma;
   } hbtr_settings_t;

   typedef enum logic [2:0] {
      FR_IDLE = 3'b001,
      FR_WAIT = 3'b010,
      FR_HOLD = 3'b100
   } hbtr_fr_state_t;

   typedef enum logic [3:0] {
      PW_IDLE = 4'b0001,
      PW_DECODE = 4'b0010,
      PW_FULL = 4'b0100,
      PW_LAT = 4'b1000
   } hbtr_pw_state_t;

endpackage

// ### verilog/hbtr_regs.sv
// Host bridge tuning registers with the small engines they steer.
// Assumes one AHB-Lite master, host bus signals on sys_clk_i, de-turbo switch asynchronous.
`timescale 1ns/10ps
`include "hbtr_cfg.svh"

module hbtr_regs #(
   parameter int REF_CYCLES = `HBTR_REF_CYC
) (
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic hreadyout_o,
   output logic hresp_o,
   output logic [31:0] hrdata_o,
   input wire hbtr_pkg::hbtr_io_wr_t io_wr_i,
   input wire logic address_strobe_n_i,
   input wire logic local_hit_i,
   input wire logic cpu_write_i,
   input wire logic post_buf_full_i,
   input wire logic cpu_held_i,
   input wire logic deturbo_switch_i,
   input wire logic parity_err_i,
   input wire logic cas_drive_bit1_i,
   output logic processor_reset_out_o,
   output logic burst_ready_n_o,
   output logic refresh_req_o,
   output logic throttle_hold_o,
   output logic parity_err_o,
   output hbtr_pkg::hbtr_settings_t settings_o
);
   import hbtr_pkg::*;

   localparam int FR_SHORT = `HBTR_NS2CYC(`HBTR_FR_SHORT_NS);
   localparam int FR_LONG = `HBTR_NS2CYC(`HBTR_FR_LONG_NS);
   localparam int DT_SHORT = `HBTR_NS2CYC(`HBTR_DT_SHORT_NS);
   localparam int DT_LONG = `HBTR_NS2CYC(`HBTR_DT_LONG_NS);
   localparam int DT_PERIOD = `HBTR_NS2CYC(`HBTR_DT_PERIOD_NS);

   typedef struct packed {
      logic [7:0] rrt;
      logic [7:0] blc;
      logic [7:0] pci;
      logic wr_pend;
      logic [7:0] wr_idx;
      logic [31:0] rdata;
      logic ready;
      hbtr_fr_state_t fr_st;
      logic [9:0] fr_cnt;
      logic rst_out;
      hbtr_pw_state_t pw_st;
      logic [1:0] pw_cnt;
      logic burst_ready_n_n;
      logic [15:0] ref_cnt;
      logic ref_req;
      logic [2:0] sw_sync;
      logic sw_stable;
      logic [10:0] dt_cnt;
      logic dt_hold;
      logic par_err;
      hbtr_settings_t set;
   } hbtr_state_t;

   hbtr_state_t st_reg;
   hbtr_state_t st_next;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [7:0] read_reg(input logic [7:0] idx, input hbtr_state_t s);
      logic [7:0] v;
      v = 8'h00;
      unique case (idx)
         `HBTR_IDX_RRT: v = s.rrt;
         `HBTR_IDX_BLC: v = s.blc;
         `HBTR_IDX_PCI: v = s.pci;
         default: v = 8'h00;
      endcase
      return v;
   endfunction

   function automatic logic [1:0] pick2(input logic sel, input logic [1:0] a,
                                        input logic [1:0] b);
      return sel ? b : a;
   endfunction

   function automatic logic [3:0] drive_ma(input logic b0, input logic b1);
      logic [3:0] ma;
      ma = 4'h8;
      unique case ({b0, b1})
         2'b00: ma = 4'h8;
         2'b10: ma = 4'h4;
         2'b01: ma = 4'hc;
         2'b11: ma = 4'h8;
      endcase
      return ma;
   endfunction

   logic addr_ok;
   logic fr_cmd;
   logic [1:0] dec_lat;

   always_comb begin
      st_next = st_reg;
      addr_ok = hsel_i && htrans_i[1] && hready_i;
      dec_lat = pick2(st_reg.blc[`HBTR_BLC_DEC_LAT], 2'd3, 2'd2);

      // ---------------------------------------------------------------
      // AHB-Lite slave, zero wait states, always OKAY
      // ---------------------------------------------------------------
      // Writes land at the end of the data phase; reads are staged from the address phase
      st_next.ready = 1'b1;
      st_next.wr_pend = 1'b0;
      if (st_reg.wr_pend) begin
         unique case (st_reg.wr_idx)
            `HBTR_IDX_RRT: st_next.rrt = hwdata_i[7:0] & `HBTR_RRT_MASK; // see R20
            `HBTR_IDX_BLC: st_next.blc = hwdata_i[7:0]; // see R20
            `HBTR_IDX_PCI: st_next.pci = hwdata_i[7:0]; // see R20
            default: st_next.blc = st_reg.blc;
         endcase
      end
      if (addr_ok) begin
         st_next.wr_pend = hwrite_i && (haddr_i[31:10] == 22'h0) && (haddr_i[1:0] == 2'b00);
         st_next.wr_idx = haddr_i[9:2];
         // Read of a just-written register sees the stored value one cycle late, so bypass
         if (!hwrite_i && haddr_i[31:10] == 22'h0 && haddr_i[1:0] == 2'b00) begin
            if (st_reg.wr_pend && st_reg.wr_idx == haddr_i[9:2]) begin
               st_next.rdata = {24'h0, read_reg(haddr_i[9:2], st_next)};
            end else begin
               st_next.rdata = {24'h0, read_reg(haddr_i[9:2], st_reg)};
            end
         end else begin
            st_next.rdata = 32'h0;
         end
      end

      // ---------------------------------------------------------------
      // Fast reset emulation
      // ---------------------------------------------------------------
      fr_cmd = st_reg.rrt[`HBTR_RRT_FR_EN] && io_wr_i.valid &&
               io_wr_i.addr == `HBTR_FR_PORT &&
               io_wr_i.data[7:4] == `HBTR_FR_DATA_HI && !io_wr_i.data[0]; // see R01
      unique case (st_reg.fr_st)
         FR_IDLE: begin
            st_next.rst_out = 1'b0;
            if (fr_cmd) begin
               st_next.fr_st = FR_WAIT;
               st_next.fr_cnt = st_reg.rrt[`HBTR_RRT_FR_LAT] ? 10'(FR_LONG - 1)
                                                            : 10'(FR_SHORT - 1); // see R02
            end
         end
         FR_WAIT: begin
            if (st_reg.fr_cnt == 10'd0) begin
               st_next.fr_st = FR_HOLD;
               st_next.rst_out = 1'b1;
               st_next.fr_cnt = 10'(`HBTR_FR_HOLD_CYC - 1); // see R03
            end else begin
               st_next.fr_cnt = st_reg.fr_cnt - 10'd1;
            end
         end
         FR_HOLD: begin
            if (st_reg.fr_cnt == 10'd0) begin
               st_next.fr_st = FR_IDLE;
               st_next.rst_out = 1'b0; // see R03
            end else begin
               st_next.fr_cnt = st_reg.fr_cnt - 10'd1;
            end
         end
      endcase

      // ---------------------------------------------------------------
      // Posted processor-to-PCI write burst ready
      // ---------------------------------------------------------------
      // The decode point alone sets the posted rates: 5T/4T per dword, 8T/7T per qword
      st_next.burst_ready_n_n = 1'b1;
      unique case (st_reg.pw_st)
         PW_IDLE: begin
            if (!address_strobe_n_i) begin
               st_next.pw_st = PW_DECODE;
               st_next.pw_cnt = 2'd1;
            end
         end
         PW_DECODE: begin
            if (st_reg.pw_cnt == dec_lat) begin // see R08 R10 R11
               if (local_hit_i || !cpu_write_i) begin
                  st_next.pw_st = PW_IDLE;
               end else if (!post_buf_full_i) begin
                  st_next.burst_ready_n_n = 1'b0; // see R09
                  st_next.pw_st = PW_IDLE;
               end else begin
                  st_next.pw_st = PW_FULL;
               end
            end else begin
               st_next.pw_cnt = st_reg.pw_cnt + 2'd1;
            end
         end
         PW_FULL: begin
            if (!post_buf_full_i) begin
               if (st_reg.blc[`HBTR_BLC_FULL_LAT]) begin
                  st_next.pw_st = PW_LAT; // see R14
               end else begin
                  st_next.burst_ready_n_n = 1'b0; // see R14
                  st_next.pw_st = PW_IDLE;
               end
            end
         end
         PW_LAT: begin
            st_next.burst_ready_n_n = 1'b0; // see R14
            st_next.pw_st = PW_IDLE;
         end
      endcase

      // ---------------------------------------------------------------
      // De-turbo throttle
      // ---------------------------------------------------------------
      // Only the last two stages are compared, so a single-cycle glitch on the pin never reaches the counter
      st_next.sw_sync = {st_reg.sw_sync[1:0], deturbo_switch_i};
      if (st_reg.sw_sync[1] == st_reg.sw_sync[2]) begin
         st_next.sw_stable = st_reg.sw_sync[2];
      end
      if (st_reg.rrt[`HBTR_RRT_DT_EN] && st_reg.sw_stable) begin // see R07
         st_next.dt_cnt = (st_reg.dt_cnt == 11'(DT_PERIOD - 1)) ? 11'd0
                                                                 : st_reg.dt_cnt + 11'd1;
         st_next.dt_hold = st_reg.rrt[`HBTR_RRT_DT_HOLD] ? (st_next.dt_cnt < 11'(DT_LONG))
                                                        : (st_next.dt_cnt < 11'(DT_SHORT));
         // see R06
      end else begin
         st_next.dt_cnt = 11'd0;
         st_next.dt_hold = 1'b0; // see R07
      end

      // ---------------------------------------------------------------
      // Refresh timer
      // ---------------------------------------------------------------
      // A refresh slot missed during hold is dropped, not queued
      st_next.ref_req = 1'b0;
      if (st_reg.ref_cnt >= (st_reg.rrt[`HBTR_RRT_SLOW_REF]
                             ? 16'(REF_CYCLES * `HBTR_SLOW_FACTOR - 1)
                             : 16'(REF_CYCLES - 1))) begin // see R04
         st_next.ref_cnt = 16'd0;
         st_next.ref_req = !(cpu_held_i || st_reg.dt_hold) ||
                           st_reg.blc[`HBTR_BLC_REF_HOLD]; // see R12
      end else begin
         st_next.ref_cnt = st_reg.ref_cnt + 16'd1;
      end

      // ---------------------------------------------------------------
      // Parity and settings
      // ---------------------------------------------------------------
      st_next.par_err = parity_err_i && !st_reg.blc[`HBTR_BLC_PAR_DIS]; // see R16
      st_next.set.cas_push_dly = pick2(st_reg.rrt[`HBTR_RRT_PUSH_DLY], 2'd2, 2'd1); // see R05
      st_next.set.cas_pulse_w = pick2(st_reg.blc[`HBTR_BLC_CAS_W], 2'd1, 2'd2); // see R13
      st_next.set.kwe_host_sync = st_reg.blc[`HBTR_BLC_KWE_SEL]; // see R15
      st_next.set.tag7 = st_reg.blc[`HBTR_BLC_TAG7];
      st_next.set.snoop_en = st_reg.blc[`HBTR_BLC_SNOOP];
      // Reserved code 10 falls back to host/2 so the PCI clock never stops
      st_next.set.pci_clk_sel = (st_reg.pci[7:6] == 2'b10) ? 2'b00 : st_reg.pci[7:6]; // see R17
      st_next.set.burst_range = st_reg.pci[`HBTR_PCI_BURST] ? 11'd1024 : 11'd512; // see R18
      st_next.set.cas_drive_ma = drive_ma(st_reg.rrt[`HBTR_RRT_DRV0], cas_drive_bit1_i); // see R19
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_reg <= '0;
         st_reg.rrt <= `HBTR_RST_RRT;
         st_reg.blc <= `HBTR_RST_BLC;
         st_reg.pci <= `HBTR_RST_PCI;
         st_reg.ready <= 1'b1;
         st_reg.fr_st <= FR_IDLE;
         st_reg.pw_st <= PW_IDLE;
         st_reg.burst_ready_n_n <= 1'b1;
         st_reg.set.cas_push_dly <= 2'd2;
         st_reg.set.cas_pulse_w <= 2'd1;
         st_reg.set.burst_range <= 11'd512;
         st_reg.set.cas_drive_ma <= 4'h8;
      end else begin
         st_reg <= st_next;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign hreadyout_o = st_reg.ready;
   assign hresp_o = 1'b0;
   assign hrdata_o = st_reg.rdata;
   assign processor_reset_out_o = st_reg.rst_out;
   assign burst_ready_n_o = st_reg.burst_ready_n_n;
   assign refresh_req_o = st_reg.ref_req;
   assign throttle_hold_o = st_reg.dt_hold;
   assign parity_err_o = st_reg.par_err;
   assign settings_o = st_reg.set;

endmodule
